/* sim/cpid_code_protect_monitor.sv */
// Concurrent checks on the code protection block ports.
`timescale 1ns/1ns
`default_nettype none
module cpid_mon (
  input wire logic        mclk,                         // System clock.
  input wire logic        rst_n,                        // Asynchronous reset.
  input wire logic        ext_we,                       // Programmer write select.
  input wire logic [15:0] ext_addr,                     // Programmer address.
  input wire logic        ext_bulk_erase,               // Programmer bulk erase.
  input wire logic [13:0] ext_rdata_q,                  // Programmer read data.
  input wire logic        ext_ack_q,                    // Programmer answer.
  input wire logic        cpu_rd,                       // CPU read pulse.
  input wire logic        cpu_wr,                       // CPU write pulse.
  input wire logic [15:0] cpu_addr,                     // CPU address.
  input wire logic [13:0] cpu_wdata,                    // CPU write data.
  input wire logic [13:0] cpu_rdata_q,                  // CPU read data.
  input wire logic        cpu_ack_q,                    // CPU answer.
  input wire logic        cpu_wr_denied_q,              // CPU write refused.
  input wire logic        cpu_busy_q,                   // CPU busy.
  input wire logic        flash_rd_q,                   // Flash read strobe.
  input wire logic        flash_wr_q,                   // Flash write strobe.
  input wire logic [15:0] flash_addr_q,                 // Flash address.
  input wire logic [13:0] flash_wdata_q,                // Flash write data.
  input wire logic [13:0] flash_rdata,                  // Flash read data.
  input wire logic        flash_read_lock_n_q,          // Read-lock state.
  input wire logic        app_region_write_lock_n_q,    // App lock state.
  input wire logic        config_region_write_lock_n_q  // Config lock state.
);
  logic rd_go;
  logic wr_go;
  assign rd_go = cpu_rd && !cpu_wr && !cpu_busy_q;
  assign wr_go = cpu_wr && !cpu_busy_q;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  AST_CPU_FLASH_RD: assert property (rd_go && cpu_addr < 16'h0800 |=>
    flash_rd_q && flash_addr_q == $past(cpu_addr) ##1 cpu_ack_q) else $error("cpu flash read");
  AST_CPU_RD_DATA: assert property (flash_rd_q && cpu_busy_q && $past(rd_go) |=>
    cpu_ack_q && cpu_rdata_q == $past(flash_rdata)) else $error("cpu flash data");
  AST_EXT_LOCKED_RD: assert property ($rose(ext_ack_q) && !ext_we &&
    ext_addr < 16'h0800 && !flash_read_lock_n_q |-> ext_rdata_q == 14'h0000)
    else $error("locked read not zero");
  AST_LOCKED_WR_SRC: assert property (flash_wr_q && !flash_read_lock_n_q |->
    $past(cpu_wr)) else $error("external flash write while locked");
  AST_CPU_WR_DENY: assert property (wr_go && cpu_addr < 16'h0800 &&
    !app_region_write_lock_n_q |=> cpu_ack_q && cpu_wr_denied_q && !flash_wr_q)
    else $error("locked self-write not refused");
  AST_CPU_WR_OK: assert property (wr_go && cpu_addr < 16'h0800 &&
    app_region_write_lock_n_q |=> flash_wr_q && !cpu_wr_denied_q &&
    flash_wdata_q == $past(cpu_wdata)) else $error("self-write lost");
  AST_DENY_ACK: assert property (cpu_wr_denied_q |-> cpu_ack_q)
    else $error("refusal without answer");
  AST_APP_STICKY: assert property ($rose(app_region_write_lock_n_q) |->
    $past(ext_bulk_erase, 2) || $past(ext_bulk_erase, 3) || $past(ext_bulk_erase, 4))
    else $error("app lock set without erase");
  AST_CFG_STICKY: assert property ($rose(config_region_write_lock_n_q) |->
    $past(ext_bulk_erase, 2) || $past(ext_bulk_erase, 3) || $past(ext_bulk_erase, 4))
    else $error("config lock set without erase");
  AST_REV_FIXED: assert property (rd_go && cpu_addr == 16'h8005 |=>
    cpu_ack_q && cpu_rdata_q[13:12] == 2'b10) else $error("revision top bits");
  AST_CFG5_UPPER: assert property (rd_go && cpu_addr == 16'h800B |=> cpu_ack_q &&
    cpu_rdata_q == {13'h1FFF, $past(flash_read_lock_n_q)}) else $error("config word five bits");
endmodule
bind cpid_code_protect cpid_mon i_cpid_mon (.mclk, .rst_n, .ext_we, .ext_addr,
  .ext_bulk_erase, .ext_rdata_q, .ext_ack_q, .cpu_rd, .cpu_wr, .cpu_addr, .cpu_wdata,
  .cpu_rdata_q, .cpu_ack_q, .cpu_wr_denied_q, .cpu_busy_q, .flash_rd_q, .flash_wr_q,
  .flash_addr_q, .flash_wdata_q, .flash_rdata, .flash_read_lock_n_q,
  .app_region_write_lock_n_q, .config_region_write_lock_n_q);
`default_nettype wire

/* sim/cpid_code_protect_tb.sv */
// Self-checking testbench for the code protection and identification block.
`timescale 1ns/1ns
`default_nettype none
module cpid_code_protect_tb;
  localparam logic [13:0]  PC  = 14'h0A5A; // Arbitrary value.
  localparam logic [5:0]   MJ  = 6'h03;
  localparam logic [5:0]   MN  = 6'h05;
  localparam logic [125:0] SER = {14'h0108, 14'h0107, 14'h0106, 14'h0105, 14'h0104,
                                  14'h0103, 14'h0102, 14'h0101, 14'h0100};
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        ext_req = 1'b0, ext_we = 1'b0, ext_bulk_erase = 1'b0;
  logic [15:0] ext_addr = 16'h0000, cpu_addr = 16'h0000;
  logic [13:0] ext_wdata = 14'h0000, cpu_wdata = 14'h0000, rq;
  logic        cpu_rd = 1'b0, cpu_wr = 1'b0, dn;
  logic [13:0] ext_rdata_q, cpu_rdata_q, flash_wdata_q, flash_rdata;
  logic        ext_ack_q, cpu_ack_q, cpu_wr_denied_q, cpu_busy_q, flash_rd_q, flash_wr_q;
  logic [15:0] flash_addr_q;
  logic        flash_read_lock_n_q, app_lock_n, sto_lock_n, boot_lock_n, cfg_lock_n;
  int          failures = 0, n_tests = 0, cyc = 0;
  logic [15:0] ta [0:10] = '{16'h8112, 16'h8114, 16'h8115, 16'h8117, 16'h811E, 16'h811F,
                             16'h8118, 16'h8119, 16'h811A, 16'h811B, 16'h811C};
  logic [13:0] te [0:10] = '{14'h3FFF, 14'h3FFF, 14'h3FFF, 14'h3FFF, 14'h3FFF, 14'h3FFF,
                             14'h0400, 14'h0800, 14'h1000, 14'h0401, 14'h0802};
  always #50 mclk = ~mclk;
  cpid_code_protect #(.PART_CODE(PC), .MAJOR_REV(MJ), .MINOR_REV(MN), .SERIAL_WORDS(SER),
    .TEMP_LOW(14'h0155), .TEMP_HIGH(14'h02AA), .CMP_REF_1X(14'h0401),
    .CMP_REF_2X(14'h0802), .CMP_REF_4X(14'h1003)) i_cpid_code_protect (
    .mclk, .rst_n, .ext_req, .ext_we, .ext_addr, .ext_wdata, .ext_bulk_erase, .ext_rdata_q,
    .ext_ack_q, .cpu_rd, .cpu_wr, .cpu_addr, .cpu_wdata, .cpu_rdata_q, .cpu_ack_q,
    .cpu_wr_denied_q, .cpu_busy_q, .flash_rd_q, .flash_wr_q, .flash_addr_q, .flash_wdata_q,
    .flash_rdata, .flash_read_lock_n_q, .app_region_write_lock_n_q(app_lock_n),
    .storage_region_write_lock_n_q(sto_lock_n), .boot_region_write_lock_n_q(boot_lock_n),
    .config_region_write_lock_n_q(cfg_lock_n));
  cpid_flash_model i_cpid_flash_model (.mclk, .flash_rd_q, .flash_wr_q, .flash_addr_q,
    .flash_wdata_q, .flash_rdata);
  task finish_test;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      $display("BAD %0t timeout", $time);
      finish_test;
    end
  end
  task chk_w(input logic [13:0] g, input logic [13:0] e);
    n_tests++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %0t word %h expected %h", $time, g, e);
    end
  endtask
  task chk_b(input logic g, input logic e);
    n_tests++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %0t flag %b expected %b", $time, g, e);
    end
  endtask
  // CPU access: one-cycle pulse, then wait for the answer pulse.
  task cpu(input logic w, input logic [15:0] a, input logic [13:0] d);
    int i;
    @(negedge mclk);
    cpu_wr = w;
    cpu_rd = !w;
    cpu_addr = a;
    cpu_wdata = d;
    @(negedge mclk);
    cpu_wr = 1'b0;
    cpu_rd = 1'b0;
    i = 0;
    while (cpu_ack_q !== 1'b1 && i < 8)
    begin
      @(negedge mclk);
      i++;
    end
    rq = cpu_rdata_q;
    dn = cpu_wr_denied_q;
  endtask
  // Programmer access: four-phase handshake on the request level.
  task ext(input logic w, input logic [15:0] a, input logic [13:0] d);
    int i;
    @(negedge mclk);
    ext_we = w;
    ext_addr = a;
    ext_wdata = d;
    ext_req = 1'b1;
    i = 0;
    while (ext_ack_q !== 1'b1 && i < 20)
    begin
      @(negedge mclk);
      i++;
    end
    rq = ext_rdata_q;
    ext_req = 1'b0;
    i = 0;
    while (ext_ack_q !== 1'b0 && i < 20)
    begin
      @(negedge mclk);
      i++;
    end
  endtask
  task cr(input logic [15:0] a, input logic [13:0] e);
    cpu(1'b0, a, 14'h0000);
    chk_w(rq, e);
  endtask
  task xr(input logic [15:0] a, input logic [13:0] e);
    ext(1'b0, a, 14'h0000);
    chk_w(rq, e);
  endtask
  task cw(input logic [15:0] a, input logic [13:0] d, input logic e);
    cpu(1'b1, a, d);
    chk_b(dn, e);
  endtask
  initial
  begin
    repeat (5) @(negedge mclk);
    rst_n = 1'b1;
    repeat (3) @(negedge mclk);
    cr(16'h800B, 14'h3FFF);
    xr(16'h800B, 14'h3FFF);
    cr(16'h8005, {2'b10, MJ, MN});
    xr(16'h8005, {2'b10, MJ, MN});
    cr(16'h8006, PC);
    xr(16'h8006, PC);
    for (int k = 0; k < 9; k++) cr(16'h8100 + 16'(k), SER[k*14 +: 14]);
    cr(16'h8109, 14'h3FFF);
    cr(16'h8113, 14'h0155);
    cr(16'h8116, 14'h02AA);
    for (int k = 0; k < 11; k++) cr(ta[k], te[k]);
    cr(16'h811D, 14'h1003);
    cw(16'h8005, 14'h0000, 1'b1);
    ext(1'b1, 16'h8006, 14'h0000);
    cw(16'h8113, 14'h0000, 1'b1);
    ext(1'b1, 16'h8100, 14'h0000);
    cr(16'h8005, {2'b10, MJ, MN});
    cr(16'h8006, PC);
    cr(16'h8113, 14'h0155);
    xr(16'h8100, SER[13:0]);
    for (int k = 0; k < 4; k++) cw(16'h8000 + 16'(k), 14'h1230 + 14'(k), 1'b0);
    for (int k = 0; k < 4; k++) xr(16'h8000 + 16'(k), 14'h1230 + 14'(k));
    ext(1'b1, 16'h8002, 14'h0ABC);
    cr(16'h8002, 14'h0ABC);
    ext(1'b1, 16'h0010, 14'h2A5A);
    xr(16'h0010, 14'h2A5A);
    cw(16'h0020, 14'h1111, 1'b0);
    cr(16'h0020, 14'h1111);
    ext(1'b1, 16'h800B, 14'h3FFE);
    cr(16'h800B, 14'h3FFE);
    chk_b(flash_read_lock_n_q, 1'b0);
    xr(16'h0010, 14'h0000);
    ext(1'b1, 16'h0010, 14'h0001);
    cr(16'h0010, 14'h2A5A);
    cw(16'h0020, 14'h2222, 1'b0);
    cw(16'h800A, 14'h3F7F, 1'b0);
    cr(16'h800A, 14'h3F7F);
    cw(16'h0020, 14'h3333, 1'b1);
    cr(16'h0020, 14'h2222);
    cw(16'h800A, 14'h3FFF, 1'b0);
    ext(1'b1, 16'h800A, 14'h3FFF);
    cr(16'h800A, 14'h3F7F);
    cw(16'h800A, 14'h3D7F, 1'b0);
    cw(16'h800A, 14'h3C7F, 1'b1);
    cr(16'h800A, 14'h3D7F);
    chk_b(cfg_lock_n, 1'b0);
    chk_b(sto_lock_n & boot_lock_n, 1'b1);
    @(negedge mclk);
    ext_bulk_erase = 1'b1;
    repeat (6) @(negedge mclk);
    ext_bulk_erase = 1'b0;
    repeat (3) @(negedge mclk);
    cr(16'h800A, 14'h3FFF);
    cr(16'h800B, 14'h3FFF);
    cr(16'h8002, 14'h3FFF);
    finish_test;
  end
endmodule
`default_nettype wire

/* sim/cpid_flash_model.sv */
// Behavioural program flash array that answers the block's flash port.
`timescale 1ns/1ns
`default_nettype none
module cpid_flash_model (
  input  wire logic        mclk,          // System clock.
  input  wire logic        flash_rd_q,    // Read strobe.
  input  wire logic        flash_wr_q,    // Write strobe.
  input  wire logic [15:0] flash_addr_q,  // Word address.
  input  wire logic [13:0] flash_wdata_q, // Write data.
  output var  logic [13:0] flash_rdata    // Read data, valid in the strobe cycle.
);
  logic [13:0] mem [0:2047];
  logic [13:0] junk = 14'h1555;
  initial
  begin
    for (int i = 0; i < 2048; i++) mem[i] = 14'h0000;
  end
  // Data is valid in the strobe cycle; outside it the bus toggles so stale values never look right.
  always @(posedge mclk)
  begin
    junk <= ~junk;
    if (flash_wr_q) mem[flash_addr_q[10:0]] <= flash_wdata_q;
  end
  always_comb flash_rdata = flash_rd_q ? mem[flash_addr_q[10:0]] : junk;
endmodule
`default_nettype wire

/* verilog/cpid_code_protect.v */
// Program flash access gate with lock bits, user ID words and identification space.
`timescale 1ns/1ns
`default_nettype none
`include "cpid_defs.vh"

module cpid_code_protect #(
  parameter [15:0]  PROG_WORDS   = `CPID_PROG_WORDS, // Program flash size in words.
  parameter [15:0]  BOOT_WORDS   = `CPID_BOOT_WORDS, // Boot region size in words.
  parameter [15:0]  SAF_WORDS    = `CPID_SAF_WORDS,  // Storage region size in words.
  parameter         BOOT_EN      = 1'b0,             // Boot region present.
  parameter         SAF_EN       = 1'b0,             // Storage region present.
  parameter [13:0]  PART_CODE    = 14'h0123,         // Arbitrary value.
  parameter [5:0]   MAJOR_REV    = 6'h01,            // Arbitrary value.
  parameter [5:0]   MINOR_REV    = 6'h00,            // Arbitrary value.
  parameter [125:0] SERIAL_WORDS = {9{14'h0000}},    // Factory serial words.
  parameter [13:0]  TEMP_LOW     = 14'h0000,         // Temperature reading, low range.
  parameter [13:0]  TEMP_HIGH    = 14'h0000,         // Temperature reading, high range.
  parameter [13:0]  ADC_REF_1X   = 14'h0400,         // ADC reference 1x, millivolts.
  parameter [13:0]  ADC_REF_2X   = 14'h0800,         // ADC reference 2x, millivolts.
  parameter [13:0]  ADC_REF_4X   = 14'h1000,         // ADC reference 4x, millivolts.
  parameter [13:0]  CMP_REF_1X   = 14'h0400,         // Comparator reference 1x.
  parameter [13:0]  CMP_REF_2X   = 14'h0800,         // Comparator reference 2x.
  parameter [13:0]  CMP_REF_4X   = 14'h1000          // Comparator reference 4x.
) (
  input  wire        mclk,                          // System clock.
  input  wire        rst_n,                         // Asynchronous reset.
  input  wire        ext_req,                       // Programmer request level.
  input  wire        ext_we,                        // Programmer write select.
  input  wire [15:0] ext_addr,                      // Programmer word address.
  input  wire [13:0] ext_wdata,                     // Programmer write data.
  input  wire        ext_bulk_erase,                // Programmer bulk erase level.
  output reg  [13:0] ext_rdata_q,                   // Programmer read data.
  output reg         ext_ack_q,                     // Programmer handshake answer.
  input  wire        cpu_rd,                        // CPU read pulse.
  input  wire        cpu_wr,                        // CPU self-write pulse.
  input  wire [15:0] cpu_addr,                      // CPU word address.
  input  wire [13:0] cpu_wdata,                     // CPU write data.
  output reg  [13:0] cpu_rdata_q,                   // CPU read data.
  output reg         cpu_ack_q,                     // CPU answer pulse.
  output reg         cpu_wr_denied_q,               // CPU write refused, with ack.
  output reg         cpu_busy_q,                    // CPU requests ignored.
  output reg         flash_rd_q,                    // Flash array read strobe.
  output reg         flash_wr_q,                    // Flash array write strobe.
  output reg  [15:0] flash_addr_q,                  // Flash array address.
  output reg  [13:0] flash_wdata_q,                 // Flash array write data.
  input  wire [13:0] flash_rdata,                   // Flash data, sampled while the strobe is high.
  output reg         flash_read_lock_n_q,           // Read-lock bit state.
  output reg         app_region_write_lock_n_q,     // App region lock state.
  output reg         storage_region_write_lock_n_q, // Storage region lock state.
  output reg         boot_region_write_lock_n_q,    // Boot region lock state.
  output reg         config_region_write_lock_n_q   // Config region lock state.
);

  localparam ST_IDLE  = 1'b0;
  localparam ST_FLASH = 1'b1;
  localparam SYNC_W   = 33;

  reg [SYNC_W-1:0] sync1_q;
  reg [SYNC_W-1:0] sync2_q;
  reg              bulk_s3_q;
  reg              state_q;
  reg              src_ext_q;
  reg [13:0]       uid_mem [0:3];
  integer          i;

  wire        ext_req_s   = sync2_q[32];
  wire        bulk_s      = sync2_q[31];
  wire        ext_we_s    = sync2_q[30];
  wire [15:0] ext_addr_s  = sync2_q[29:14];
  wire [13:0] ext_wdata_s = sync2_q[13:0];
  wire        bulk_pulse  = bulk_s & ~bulk_s3_q;

  function in_span;
    input [15:0] addr;
    input [15:0] first;
    input [15:0] last;
    begin
      in_span = (addr >= first) && (addr <= last);
    end
  endfunction

  function [13:0] set_bit;
    input [13:0] word;
    input integer pos;
    input        val;
    begin
      set_bit = word;
      set_bit[pos] = val;
    end
  endfunction

  // CPU requests win a tie; a programmer request waits in the synchroniser.
  wire        cpu_go    = (state_q == ST_IDLE) && (cpu_rd || cpu_wr);
  wire        ext_go    = (state_q == ST_IDLE) && !cpu_go && ext_req_s && !ext_ack_q;
  wire        req_go    = cpu_go || ext_go;
  wire        req_ext   = !cpu_go;
  wire        req_we    = cpu_go ? cpu_wr : ext_we_s;
  wire [15:0] req_addr  = cpu_go ? cpu_addr : ext_addr_s;
  wire [13:0] req_wdata = cpu_go ? cpu_wdata : ext_wdata_s;

  // Only the program flash span is gated by the read-lock bit.
  wire prog_hit = req_addr < PROG_WORDS;
  wire uid_hit  = in_span(req_addr, `CPID_UID_FIRST, `CPID_UID_LAST);
  wire cfg_hit  = in_span(req_addr, `CPID_CFG_FIRST, `CPID_CFG_LAST);
  wire info_hit = in_span(req_addr, `CPID_INFO_FIRST, `CPID_INFO_LAST);
  wire boot_hit = BOOT_EN && (req_addr < BOOT_WORDS);
  wire saf_hit  = SAF_EN && (req_addr >= PROG_WORDS - SAF_WORDS);

  wire self_unlocked = boot_hit ? boot_region_write_lock_n_q :
                       saf_hit  ? storage_region_write_lock_n_q :
                                  app_region_write_lock_n_q;

  reg wr_allow;
  always @*
  begin
    wr_allow = 1'b0;
    if (prog_hit)
    begin
      wr_allow = req_ext ? flash_read_lock_n_q : self_unlocked;
    end
    else if (uid_hit)
    begin
      wr_allow = 1'b1;
    end
    else if (cfg_hit)
    begin
      wr_allow = req_ext ? 1'b1 : config_region_write_lock_n_q;
    end
  end

  wire [13:0] info_data;

  cpid_info_rom #(
    .SERIAL_WORDS (SERIAL_WORDS),
    .TEMP_LOW     (TEMP_LOW),
    .TEMP_HIGH    (TEMP_HIGH),
    .ADC_REF_1X   (ADC_REF_1X),
    .ADC_REF_2X   (ADC_REF_2X),
    .ADC_REF_4X   (ADC_REF_4X),
    .CMP_REF_1X   (CMP_REF_1X),
    .CMP_REF_2X   (CMP_REF_2X),
    .CMP_REF_4X   (CMP_REF_4X)
  ) u_info (
    .offset (req_addr[4:0]),
    .data   (info_data)
  );

  reg [13:0] cfg4_word;
  reg [13:0] id_rdata;
  always @*
  begin
    cfg4_word = `CPID_ERASED;
    cfg4_word = set_bit(cfg4_word, `CPID_APP_BIT, app_region_write_lock_n_q);
    cfg4_word = set_bit(cfg4_word, `CPID_BOOT_BIT, boot_region_write_lock_n_q);
    cfg4_word = set_bit(cfg4_word, `CPID_CFG_BIT, config_region_write_lock_n_q);
    cfg4_word = set_bit(cfg4_word, `CPID_SAF_BIT, storage_region_write_lock_n_q);
    id_rdata = `CPID_ZERO;
    if (uid_hit)
    begin
      id_rdata = uid_mem[req_addr[1:0]];
    end
    else if (info_hit)
    begin
      id_rdata = info_data;
    end
    else
    begin
      case (req_addr)
        `CPID_PART_ADDR: id_rdata = PART_CODE;
        `CPID_REV_ADDR:  id_rdata = {`CPID_REV_FIXED, MAJOR_REV, MINOR_REV};
        `CPID_CFG4_ADDR: id_rdata = cfg4_word;
        `CPID_CFG5_ADDR: id_rdata = set_bit(`CPID_ERASED, `CPID_CP_BIT,
                                            flash_read_lock_n_q);
        default:         id_rdata = cfg_hit ? `CPID_ERASED : `CPID_ZERO;
      endcase
    end
  end

  // Programmer pins come from another clock domain.
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_q   <= {SYNC_W{1'b0}};
      sync2_q   <= {SYNC_W{1'b0}};
      bulk_s3_q <= 1'b0;
    end
    else
    begin
      sync1_q   <= {ext_req, ext_bulk_erase, ext_we, ext_addr, ext_wdata};
      sync2_q   <= sync1_q;
      bulk_s3_q <= bulk_s;
    end
  end

  // Lock bits and user IDs reset to the blank state of an erased part.
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q                       <= ST_IDLE;
      src_ext_q                     <= 1'b0;
      ext_rdata_q                   <= `CPID_ZERO;
      ext_ack_q                     <= 1'b0;
      cpu_rdata_q                   <= `CPID_ZERO;
      cpu_ack_q                     <= 1'b0;
      cpu_wr_denied_q               <= 1'b0;
      cpu_busy_q                    <= 1'b0;
      flash_rd_q                    <= 1'b0;
      flash_wr_q                    <= 1'b0;
      flash_addr_q                  <= 16'h0000;
      flash_wdata_q                 <= `CPID_ZERO;
      flash_read_lock_n_q           <= 1'b1;
      app_region_write_lock_n_q     <= 1'b1;
      storage_region_write_lock_n_q <= 1'b1;
      boot_region_write_lock_n_q    <= 1'b1;
      config_region_write_lock_n_q  <= 1'b1;
      for (i = 0; i < 4; i = i + 1)
      begin
        uid_mem[i] <= `CPID_ERASED;
      end
    end
    else
    begin
      cpu_ack_q       <= 1'b0;
      cpu_wr_denied_q <= 1'b0;
      flash_rd_q      <= 1'b0;
      flash_wr_q      <= 1'b0;
      if (!ext_req_s)
      begin
        ext_ack_q <= 1'b0;
      end
      case (state_q)
        ST_IDLE:
        begin
          if (req_go && req_we)
          begin
            if (wr_allow && prog_hit)
            begin
              flash_wr_q    <= 1'b1;
              flash_addr_q  <= req_addr;
              flash_wdata_q <= req_wdata;
            end
            if (wr_allow && uid_hit)
            begin
              uid_mem[req_addr[1:0]] <= req_wdata;
            end
            if (wr_allow && (req_addr == `CPID_CFG4_ADDR))
            begin
              app_region_write_lock_n_q     <= app_region_write_lock_n_q &
                                               req_wdata[`CPID_APP_BIT];
              boot_region_write_lock_n_q    <= boot_region_write_lock_n_q &
                                               req_wdata[`CPID_BOOT_BIT];
              config_region_write_lock_n_q  <= config_region_write_lock_n_q &
                                               req_wdata[`CPID_CFG_BIT];
              storage_region_write_lock_n_q <= storage_region_write_lock_n_q &
                                               req_wdata[`CPID_SAF_BIT];
            end
            if (wr_allow && (req_addr == `CPID_CFG5_ADDR))
            begin
              flash_read_lock_n_q <= flash_read_lock_n_q & req_wdata[`CPID_CP_BIT];
            end
            if (req_ext)
            begin
              ext_ack_q   <= 1'b1;
              ext_rdata_q <= `CPID_ZERO;
            end
            else
            begin
              cpu_ack_q       <= 1'b1;
              cpu_rdata_q     <= `CPID_ZERO;
              cpu_wr_denied_q <= !wr_allow;
            end
          end
          else if (req_go)
          begin
            if (prog_hit && req_ext && !flash_read_lock_n_q)
            begin
              ext_ack_q   <= 1'b1;
              ext_rdata_q <= `CPID_ZERO;
            end
            else if (prog_hit)
            begin
              flash_rd_q   <= 1'b1;
              flash_addr_q <= req_addr;
              src_ext_q    <= req_ext;
              cpu_busy_q   <= 1'b1;
              state_q      <= ST_FLASH;
            end
            else if (req_ext)
            begin
              ext_ack_q   <= 1'b1;
              ext_rdata_q <= id_rdata;
            end
            else
            begin
              cpu_ack_q   <= 1'b1;
              cpu_rdata_q <= id_rdata;
            end
          end
        end
        ST_FLASH:
        begin
          cpu_busy_q <= 1'b0;
          state_q    <= ST_IDLE;
          if (src_ext_q)
          begin
            ext_ack_q   <= 1'b1;
            ext_rdata_q <= flash_rdata;
          end
          else
          begin
            cpu_ack_q   <= 1'b1;
            cpu_rdata_q <= flash_rdata;
          end
        end
        default:
        begin
          state_q    <= ST_IDLE;
          cpu_busy_q <= 1'b0;
        end
      endcase
      // Bulk erase overrides any lock-bit or user ID write landing in the same cycle.
      if (bulk_pulse)
      begin
        flash_read_lock_n_q           <= 1'b1;
        app_region_write_lock_n_q     <= 1'b1;
        storage_region_write_lock_n_q <= 1'b1;
        boot_region_write_lock_n_q    <= 1'b1;
        config_region_write_lock_n_q  <= 1'b1;
        for (i = 0; i < 4; i = i + 1)
        begin
          uid_mem[i] <= `CPID_ERASED;
        end
      end
    end
  end

endmodule
`default_nettype wire

/* verilog/cpid_defs.vh */
// Address map, field positions and reset values for the code protection block.
`ifndef CPID_DEFS_VH
`define CPID_DEFS_VH

// Word widths and the erased and zero word values.
`define CPID_ADDR_W           16
`define CPID_DATA_W           14
`define CPID_ERASED           14'h3FFF
`define CPID_ZERO             14'h0000

// Program flash sizing and the optional boot and storage regions.
`define CPID_PROG_WORDS       16'h0800
`define CPID_BOOT_WORDS       16'h0200
`define CPID_SAF_WORDS        16'h0080

// User ID words.
`define CPID_UID_FIRST        16'h8000
`define CPID_UID_LAST         16'h8003

// Fixed identification words.
`define CPID_REV_ADDR         16'h8005
`define CPID_PART_ADDR        16'h8006

// Configuration words; words four and five hold the lock bits.
`define CPID_CFG_FIRST        16'h8007
`define CPID_CFG_LAST         16'h800B
`define CPID_CFG4_ADDR        16'h800A
`define CPID_CFG5_ADDR        16'h800B

// Lock bit positions inside the configuration words.
`define CPID_CP_BIT           0
`define CPID_APP_BIT          7
`define CPID_BOOT_BIT         8
`define CPID_CFG_BIT          9
`define CPID_SAF_BIT          11

// Revision word layout.
`define CPID_REV_FIXED        2'b10
`define CPID_REV_FIXED_HI     13
`define CPID_REV_FIXED_LO     12
`define CPID_MAJOR_HI         11
`define CPID_MAJOR_LO         6
`define CPID_MINOR_HI         5
`define CPID_MINOR_LO         0

// Device information area span and word offsets inside it.
`define CPID_INFO_FIRST       16'h8100
`define CPID_INFO_LAST        16'h811F
`define CPID_INFO_SERIAL_LAST 5'h08
`define CPID_INFO_RESERVED    5'h09
`define CPID_INFO_TEMP_LOW    5'h13
`define CPID_INFO_TEMP_HIGH   5'h16
`define CPID_INFO_ADC_1X      5'h18
`define CPID_INFO_ADC_2X      5'h19
`define CPID_INFO_ADC_4X      5'h1A
`define CPID_INFO_CMP_1X      5'h1B
`define CPID_INFO_CMP_2X      5'h1C
`define CPID_INFO_CMP_4X      5'h1D

`endif

/* verilog/cpid_info_rom.v */
// Factory information area: serial words, temperature and reference calibration.
`timescale 1ns/1ns
`default_nettype none
`include "cpid_defs.vh"

module cpid_info_rom #(
  parameter [125:0] SERIAL_WORDS = {9{14'h0000}}, // Factory serial words, word 0 lowest.
  parameter [13:0]  TEMP_LOW     = 14'h0000,      // Temperature reading, low range.
  parameter [13:0]  TEMP_HIGH    = 14'h0000,      // Temperature reading, high range.
  parameter [13:0]  ADC_REF_1X   = 14'h0000,      // ADC reference at 1x, millivolts.
  parameter [13:0]  ADC_REF_2X   = 14'h0000,      // ADC reference at 2x, millivolts.
  parameter [13:0]  ADC_REF_4X   = 14'h0000,      // ADC reference at 4x, millivolts.
  parameter [13:0]  CMP_REF_1X   = 14'h0000,      // Comparator reference at 1x, millivolts.
  parameter [13:0]  CMP_REF_2X   = 14'h0000,      // Comparator reference at 2x, millivolts.
  parameter [13:0]  CMP_REF_4X   = 14'h0000       // Comparator reference at 4x, millivolts.
) (
  input  wire [4:0]  offset, // Word offset inside the information area.
  output reg  [13:0] data    // Word at that offset.
);

  always @*
  begin
    data = `CPID_ERASED;
    if (offset <= `CPID_INFO_SERIAL_LAST)
    begin
      data = SERIAL_WORDS[offset[3:0]*14 +: 14];
    end
    else
    begin
      case (offset)
        `CPID_INFO_RESERVED:  data = `CPID_ERASED;
        `CPID_INFO_TEMP_LOW:  data = TEMP_LOW;
        `CPID_INFO_TEMP_HIGH: data = TEMP_HIGH;
        `CPID_INFO_ADC_1X:    data = ADC_REF_1X;
        `CPID_INFO_ADC_2X:    data = ADC_REF_2X;
        `CPID_INFO_ADC_4X:    data = ADC_REF_4X;
        `CPID_INFO_CMP_1X:    data = CMP_REF_1X;
        `CPID_INFO_CMP_2X:    data = CMP_REF_2X;
        `CPID_INFO_CMP_4X:    data = CMP_REF_4X;
        default:              data = `CPID_ERASED;
      endcase
    end
  end

endmodule
`default_nettype wire
